// ### verilog/agt_regs.sv
// right agc timing and adc path register bank on the byte register port
`timescale 1ns/1ns
`include "agt_params.svh"
module agt_regs import agt_pkg::*; (
	input wire logic clk,
	input wire logic sys_rst,
	// register port from the control-bus slave, one-cycle strobes
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire agt_byte_t reg_addr,
	input wire agt_byte_t reg_wdata,
	output agt_byte_t reg_rdata,
	output logic reg_ack,
	// legacy times from the older right agc register, in ms
	input wire agt_ms_t legacy_attack_ms,
	input wire agt_ms_t legacy_decay_ms,
	// decimation ratio in half steps: 0 = 1.0 ... 10 = 6.0
	input wire logic [3:0] adc_decimation_ratio,
	// control-bus error event from the bus slave
	input wire logic bus_err_event,
	input wire logic dacs_powered_down,
	input wire logic hpf_enable,
	// outputs to the agc, record path and bus slave
	output agt_ms_t attack_ms,
	output agt_ms_t decay_ms,
	output logic attack_prog,
	output logic decay_prog,
	output logic hpf_left_prog,
	output logic hpf_right_prog,
	output logic fx_on_adc,
	output logic bus_det_en,
	output logic bus_err_clear,
	output logic bus_err_status
);
	// ==========================================================
	// storage
	agt_byte_t attack_q; // attack time register
	agt_byte_t decay_q; // decay time register
	agt_byte_t path_q; // writable path bits
	logic err_q; // sticky bus error status
	agt_acc_e acc_q; // last access kind
	agt_acc_e acc_d;
	// ==========================================================
	// address decode
	wire hit_atk = reg_addr == `AGT_OFS_ATTACK;
	wire hit_dcy = reg_addr == `AGT_OFS_DECAY;
	wire hit_path = reg_addr == `AGT_OFS_PATH;
	// a read of the path register clears the status
	wire path_read = reg_rd && hit_path;
	// detection only while the disable bit is clear
	wire det_on = !path_q[`AGT_BUS_DET_OFF_BIT];
	wire err_set = det_on && bus_err_event;
	// reserved bits are masked so stray ones never reach logic
	wire agt_byte_t wmask_time = `AGT_TIME_WMASK;
	wire agt_byte_t wmask_path = `AGT_PATH_WMASK;
	// read mux, unmapped addresses read zero
	wire agt_byte_t rd_mux = hit_atk ? attack_q :
		hit_dcy ? decay_q :
		hit_path ? (path_q | {7'h00, err_q}) : 8'h00;
	assign acc_d = reg_wr ? AGT_WRITE : reg_rd ? AGT_READ : AGT_IDLE;
	// ==========================================================
	// register writes; host must write reserved bits zero, we mask anyway
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			attack_q <= `AGT_RST_VAL;
			decay_q <= `AGT_RST_VAL;
			path_q <= `AGT_RST_VAL;
		end else if (reg_wr) begin
			if (hit_atk) attack_q <= reg_wdata & wmask_time;
			if (hit_dcy) decay_q <= reg_wdata & wmask_time;
			if (hit_path) path_q <= reg_wdata & wmask_path;
		end
	end
	// sticky status, set beats read clear
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			err_q <= 1'b0;
		end else if (err_set) begin
			err_q <= 1'b1;
		end else if (path_read) begin
			err_q <= 1'b0;
		end
	end
	// read data is registered, ack one cycle after the strobe
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			reg_rdata <= 8'h00;
			acc_q <= AGT_IDLE;
		end else begin
			reg_rdata <= reg_rd ? rd_mux : reg_rdata;
			acc_q <= acc_d;
		end
	end
	assign reg_ack = acc_q != AGT_IDLE;
	// ==========================================================
	// decay cap per decimation ratio
	agt_ms_t cap_ms;
	always_comb begin
		case (adc_decimation_ratio)
			4'd0: cap_ms = `AGT_CAP_R10;
			4'd1: cap_ms = `AGT_CAP_R15;
			4'd2: cap_ms = `AGT_CAP_R20;
			4'd3: cap_ms = `AGT_CAP_R25;
			4'd4, 4'd5: cap_ms = `AGT_CAP_R35;
			4'd6, 4'd7: cap_ms = `AGT_CAP_R45;
			4'd8: cap_ms = `AGT_CAP_R50;
			default: cap_ms = `AGT_CAP_R60;
		endcase
	end
	// ==========================================================
	// timing channels, attack cap is unused
	agt_time_sel #(.IS_DECAY(1'b0)) u_attack (
		.clk(clk),
		.sys_rst(sys_rst),
		.reg_val(attack_q),
		.legacy_ms(legacy_attack_ms),
		.cap_ms(cap_ms),
		.time_ms(attack_ms),
		.use_prog(attack_prog)
	);
	agt_time_sel #(.IS_DECAY(1'b1)) u_decay (
		.clk(clk),
		.sys_rst(sys_rst),
		.reg_val(decay_q),
		.legacy_ms(legacy_decay_ms),
		.cap_ms(cap_ms),
		.time_ms(decay_ms),
		.use_prog(decay_prog)
	);
	// ==========================================================
	// programmable hpf coefficients only while hpf is on
	assign hpf_left_prog = hpf_enable && path_q[`AGT_HPF_LEFT_BIT];
	assign hpf_right_prog = hpf_enable && path_q[`AGT_HPF_RIGHT_BIT];
	// effects filter joins the adc only with both dacs down
	assign fx_on_adc = path_q[`AGT_FX_PATH_BIT] && dacs_powered_down;
	// recovery pulse to the bus slave on each detected error
	assign bus_det_en = det_on;
	assign bus_err_clear = err_set;
	assign bus_err_status = err_q;
	// ==========================================================
	// checks
	// detected error raises status
	err_set_a: assert property (@(posedge clk) disable iff (sys_rst)
		err_set |=> err_q)
		else $error("bus error status not set");
	// read without new error clears status
	err_clr_a: assert property (@(posedge clk) disable iff (sys_rst)
		path_read && !err_set |=> !err_q)
		else $error("status not cleared by read");
	det_off_a: assert property (@(posedge clk) disable iff (sys_rst)
		!det_on && !err_q |=> !err_q)
		else $error("status set while detector off");
	// effects path blocked while a dac is up
	fx_gate_a: assert property (@(posedge clk) disable iff (sys_rst)
		!dacs_powered_down |-> !fx_on_adc)
		else $error("effects filter on with dac up");
	// left coefficient select follows bit seven
	hpf_left_a: assert property (@(posedge clk) disable iff (sys_rst)
		reg_wr && hit_path && hpf_enable ##1 hpf_enable |-> hpf_left_prog == $past(reg_wdata[7]))
		else $error("left hpf select wrong");
	// right coefficient select follows bit six
	hpf_right_a: assert property (@(posedge clk) disable iff (sys_rst)
		reg_wr && hit_path ##1 hpf_enable |-> hpf_right_prog == $past(reg_wdata[6]))
		else $error("right hpf select wrong");
	rsvd_zero_a: assert property (@(posedge clk) disable iff (sys_rst)
		attack_q[1:0] == 2'b00 && decay_q[1:0] == 2'b00 && path_q[5:4] == 2'b00)
		else $error("reserved bits stored");
	// decay select bit drives the source flag
	dcy_src_a: assert property (@(posedge clk) disable iff (sys_rst)
		reg_wr && hit_dcy |=> ##1 decay_prog == $past(reg_wdata[7], 2))
		else $error("decay source flag wrong");
	cap_one_a: assert property (@(posedge clk) disable iff (sys_rst)
		adc_decimation_ratio == 4'd0 ##1 adc_decimation_ratio == 4'd0 |-> decay_ms <= `AGT_CAP_R10)
		else $error("decay cap at ratio one exceeded");
	// ==========================================================
	// readback, source and path checks
	// the port has no wait states, so every strobe must be answered next edge;
	// a slave that stretched its strobe would see a second access, which for the
	// path register would clear a freshly raised status twice
	// read answered next edge
	ack_follow_a: assert property (@(posedge clk) disable iff (sys_rst)
		reg_rd |=> reg_ack)
		else $error("read not acknowledged");
	err_read_a: assert property (@(posedge clk) disable iff (sys_rst)
		reg_rd && hit_path |=> reg_rdata[0] == $past(err_q))
		else $error("status bit not returned on read");
	err_hold_a: assert property (@(posedge clk) disable iff (sys_rst)
		err_q && !path_read |=> err_q)
		else $error("status lost without a read");
	path_rsvd_a: assert property (@(posedge clk) disable iff (sys_rst)
		reg_rd && hit_path |=> reg_rdata[5:4] == 2'b00 && !reg_rdata[1])
		else $error("path reserved bits read nonzero");
	time_rsvd_a: assert property (@(posedge clk) disable iff (sys_rst)
		reg_rd && (hit_atk || hit_dcy) |=> reg_rdata[1:0] == 2'b00)
		else $error("time reserved bits read nonzero");
	atk_src_a: assert property (@(posedge clk) disable iff (sys_rst)
		reg_wr && hit_atk |=> ##1 attack_prog == $past(reg_wdata[7], 2))
		else $error("attack source flag wrong");
	fx_write_a: assert property (@(posedge clk) disable iff (sys_rst)
		reg_wr && hit_path ##1 dacs_powered_down |-> fx_on_adc == $past(reg_wdata[3]))
		else $error("effects path select wrong");
	det_write_a: assert property (@(posedge clk) disable iff (sys_rst)
		reg_wr && hit_path |=> bus_det_en == !$past(reg_wdata[2]))
		else $error("detector enable wrong");
	cap_top_a: assert property (@(posedge clk) disable iff (sys_rst)
		adc_decimation_ratio >= 4'd9 ##1 adc_decimation_ratio >= 4'd9 |-> decay_ms <= `AGT_CAP_R60)
		else $error("decay cap at top ratio exceeded");
	wr_cov: cover property (@(posedge clk) reg_wr && hit_atk);
	rd_err_cov: cover property (@(posedge clk) path_read && err_q);
	err_cov: cover property (@(posedge clk) err_set ##1 path_read);
	fx_cov: cover property (@(posedge clk) fx_on_adc);
	race_cov: cover property (@(posedge clk) err_set && path_read);
endmodule // agt_regs

// ### verilog/agt_params.svh
// constants for the right agc timing and adc path register bank
// Function
// - attack select clear uses legacy attack source
// - baseline attack codes give 7/8/10/11 ms
// - attack multiplier is two to the code
// - decay select clear uses legacy decay source
// - baseline decay codes give 50/150/250/350 ms
// - decay multiplier is two to the code
// - decay time capped by decimation ratio
// - left hpf coefficient select bit seven
// - right hpf coefficient select bit six
// - effects filter on adc only dacs down
// - bus error detector enabled while bit clear
// - bus error status set, cleared on read
`ifndef AGT_PARAMS_SVH
`define AGT_PARAMS_SVH
// ==========================================================
// register offsets
`define AGT_OFS_ATTACK 8'h69
`define AGT_OFS_DECAY 8'h6a
`define AGT_OFS_PATH 8'h6b
// ==========================================================
// field positions
`define AGT_SEL_BIT 7
`define AGT_BASE_HI 6
`define AGT_BASE_LO 5
`define AGT_MUL_HI 4
`define AGT_MUL_LO 2
`define AGT_HPF_LEFT_BIT 7
`define AGT_HPF_RIGHT_BIT 6
`define AGT_FX_PATH_BIT 3
`define AGT_BUS_DET_OFF_BIT 2
`define AGT_BUS_ERR_BIT 0
// ==========================================================
// reset values and writable masks
`define AGT_RST_VAL 8'h00
`define AGT_TIME_WMASK 8'hfc
`define AGT_PATH_WMASK 8'hcc
// ==========================================================
// times in milliseconds
`define AGT_ATK_MS0 16'd7
`define AGT_ATK_MS1 16'd8
`define AGT_ATK_MS2 16'd10
`define AGT_ATK_MS3 16'd11
`define AGT_DCY_MS0 16'd50
`define AGT_DCY_MS1 16'd150
`define AGT_DCY_MS2 16'd250
`define AGT_DCY_MS3 16'd350
// decay caps in ms indexed by ratio in half steps (code 0 = ratio 1)
`define AGT_CAP_R10 24'd4000
`define AGT_CAP_R15 24'd5600
`define AGT_CAP_R20 24'd8000
`define AGT_CAP_R25 24'd9600
`define AGT_CAP_R35 24'd11200
`define AGT_CAP_R45 24'd16000
`define AGT_CAP_R50 24'd19200
`define AGT_CAP_R60 24'd22400
`endif

// ### verilog/agt_pkg.sv
// types for the right agc timing and adc path register bank
package agt_pkg;
	// register bus access state, gray coded
	typedef enum logic [1:0] {
		AGT_IDLE = 2'b00,
		AGT_WRITE = 2'b01,
		AGT_READ = 2'b11
	} agt_acc_e;
	typedef logic [7:0] agt_byte_t;
	typedef logic [23:0] agt_ms_t;
endpackage

// ### verilog/agt_time_sel.sv
// one timing channel: legacy or baseline times power-of-two factor
`timescale 1ns/1ns
`include "agt_params.svh"
module agt_time_sel import agt_pkg::*; #(
	parameter bit IS_DECAY = 1'b0
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire agt_byte_t reg_val,
	input wire agt_ms_t legacy_ms,
	input wire agt_ms_t cap_ms,
	output agt_ms_t time_ms,
	output logic use_prog
);
	// ==========================================================
	// field decode
	wire [1:0] base_code = reg_val[`AGT_BASE_HI:`AGT_BASE_LO];
	wire [2:0] mul_code = reg_val[`AGT_MUL_HI:`AGT_MUL_LO];
	wire sel = reg_val[`AGT_SEL_BIT];
	logic [15:0] base_ms;
	always_comb begin
		case (base_code)
			2'b00: base_ms = IS_DECAY ? `AGT_DCY_MS0 : `AGT_ATK_MS0;
			2'b01: base_ms = IS_DECAY ? `AGT_DCY_MS1 : `AGT_ATK_MS1;
			2'b10: base_ms = IS_DECAY ? `AGT_DCY_MS2 : `AGT_ATK_MS2;
			default: base_ms = IS_DECAY ? `AGT_DCY_MS3 : `AGT_ATK_MS3;
		endcase
	end
	// baseline scaled by shifting, widest is 350*128
	wire agt_ms_t prog_ms = agt_ms_t'({8'h00, base_ms} << mul_code);
	wire agt_ms_t raw_ms = sel ? prog_ms : legacy_ms;
	// cap only matters for decay; attack passes through uncapped
	wire agt_ms_t lim_ms = (IS_DECAY && raw_ms > cap_ms) ? cap_ms : raw_ms;
	// registered so the agc sees a glitch-free value
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			time_ms <= '0;
			use_prog <= 1'b0;
		end else begin
			time_ms <= lim_ms;
			use_prog <= sel;
		end
	end
	// programmable attack result matches baseline times factor
	prog_val_a: assert property (@(posedge clk) disable iff (sys_rst)
		sel && !IS_DECAY |=> time_ms == agt_ms_t'($past(base_ms)) << $past(mul_code))
		else $error("programmable attack time wrong");
	// legacy attack time passes through when select is clear
	legacy_val_a: assert property (@(posedge clk) disable iff (sys_rst)
		!sel && !IS_DECAY |=> time_ms == $past(legacy_ms))
		else $error("legacy time not used");
	decay_cap_a: assert property (@(posedge clk) disable iff (sys_rst)
		IS_DECAY |=> time_ms <= $past(cap_ms))
		else $error("decay time above cap");
endmodule // agt_time_sel

// ### sim/agt_host_model.sv
// host controller model issuing single-byte accesses on the register port
`timescale 1ns/1ns
module agt_host_model import agt_pkg::*; (
	input wire logic clk,
	input wire logic reg_ack,
	input wire agt_byte_t reg_rdata,
	output logic reg_wr,
	output logic reg_rd,
	output agt_byte_t reg_addr,
	output agt_byte_t reg_wdata
);
	// ==========================================================
	// idle bus at time zero
	initial begin
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
	end

	// ==========================================================
	// one access: strobe for one edge, answer sampled one edge later
	task automatic access(input logic wr, input agt_byte_t a, input agt_byte_t d,
		output agt_byte_t q);
		@(posedge clk);
		reg_wr <= wr;
		reg_rd <= ~wr;
		reg_addr <= a;
		reg_wdata <= d & ((a == 8'h6b) ? 8'hcc : 8'hfc);
		@(posedge clk);
		reg_wr <= 1'b0;
		reg_rd <= 1'b0;
		@(posedge clk);
		// a missing ack poisons the returned byte so the compare fails
		q = reg_ack ? reg_rdata : 8'hxx;
		// released lines show the inverse, never a stale value
		reg_addr <= ~a;
		reg_wdata <= ~d;
	endtask
endmodule // agt_host_model

// ### sim/tb.sv
// self-checking bench for the right agc timing and adc path register bank
`timescale 1ns/1ns
`include "agt_params.svh"
module tb import agt_pkg::*;;
	logic clk = 1'b0;
	logic sys_rst = 1'b1;
	logic reg_wr, reg_rd, reg_ack;
	agt_byte_t reg_addr, reg_wdata, reg_rdata, q;
	agt_ms_t legacy_attack_ms = 24'h7b;
	agt_ms_t legacy_decay_ms = 24'h1c8;
	logic [3:0] adc_decimation_ratio = 4'ha;
	logic bus_err_event = 1'b0;
	logic dacs_powered_down = 1'b1;
	logic hpf_enable = 1'b1;
	agt_ms_t attack_ms, decay_ms;
	logic attack_prog, decay_prog, hpf_left_prog, hpf_right_prog;
	logic fx_on_adc, bus_det_en, bus_err_clear, bus_err_status;
	int bad_count = 0;
	int n_compared = 0;
	// expected tables: baselines in ms and decay caps per half-step ratio
	agt_ms_t atk[4] = '{24'h7, 24'h8, 24'ha, 24'hb};
	agt_ms_t dcy[4] = '{24'h32, 24'h96, 24'hfa, 24'h15e};
	agt_ms_t cap[11] = '{24'hfa0, 24'h15e0, 24'h1f40, 24'h2580, 24'h2bc0, 24'h2bc0,
		24'h3e80, 24'h3e80, 24'h4b00, 24'h5780, 24'h5780};
	agt_byte_t pv[4] = '{8'h80, 8'h40, 8'h08, 8'h04};

	always #50 clk = ~clk;

	agt_regs dut_u (.clk(clk), .sys_rst(sys_rst), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_ack(reg_ack),
		.legacy_attack_ms(legacy_attack_ms), .legacy_decay_ms(legacy_decay_ms),
		.adc_decimation_ratio(adc_decimation_ratio), .bus_err_event(bus_err_event),
		.dacs_powered_down(dacs_powered_down), .hpf_enable(hpf_enable),
		.attack_ms(attack_ms), .decay_ms(decay_ms), .attack_prog(attack_prog),
		.decay_prog(decay_prog), .hpf_left_prog(hpf_left_prog),
		.hpf_right_prog(hpf_right_prog), .fx_on_adc(fx_on_adc), .bus_det_en(bus_det_en),
		.bus_err_clear(bus_err_clear), .bus_err_status(bus_err_status));

	agt_host_model host_u (.clk(clk), .reg_ack(reg_ack), .reg_rdata(reg_rdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata));

	// ==========================================================
	// helpers: compare, settle, register access
	task automatic chk(input logic [23:0] got, input logic [23:0] exp);
		n_compared++;
		if (got !== exp) begin
			bad_count++;
			$display("[ERR] t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic nap;
		repeat (2) @(negedge clk);
	endtask
	task automatic wr(input agt_byte_t a, input agt_byte_t d);
		host_u.access(1'b1, a, d, q);
	endtask
	task automatic rd(input agt_byte_t a, input agt_byte_t e);
		host_u.access(1'b0, a, 8'h00, q);
		chk(24'(q), 24'(e));
	endtask
	// one error event, then status and clear strobe compared
	task automatic pulse(input logic e);
		@(posedge clk);
		bus_err_event <= 1'b1;
		@(negedge clk);
		chk(24'(bus_err_clear), 24'(e));
		@(posedge clk);
		bus_err_event <= 1'b0;
		nap;
		chk(24'(bus_err_status), 24'(e));
	endtask
	task automatic report_and_stop;
		$display("compared %0d mismatches %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	// ==========================================================
	// watchdog: more than twenty times the expected run length
	initial begin
		#1000000;
		bad_count++;
		report_and_stop;
	end

	// ==========================================================
	// main sequence
	initial begin
		repeat (3) @(posedge clk);
		sys_rst <= 1'b0;
		nap;
		rd(`AGT_OFS_ATTACK, 8'h00);
		rd(`AGT_OFS_DECAY, 8'h00);
		rd(`AGT_OFS_PATH, 8'h00);
		chk(attack_ms, 24'h7b);
		chk(decay_ms, 24'h1c8);
		// every baseline and multiplier code, both channels
		for (int b = 0; b < 4; b++) begin
			for (int m = 0; m < 8; m++) begin
				wr(`AGT_OFS_ATTACK, {1'b1, 2'(b), 3'(m), 2'b00});
				wr(`AGT_OFS_DECAY, {1'b1, 2'(b), 3'(m), 2'b00});
				nap;
				chk(attack_ms, atk[b] << m);
				chk(decay_ms, ((dcy[b] << m) > 24'h5780) ? 24'h5780 : dcy[b] << m);
				chk(24'({attack_prog, decay_prog}), 24'h3);
			end
		end
		rd(`AGT_OFS_DECAY, 8'hfc);
		// longest decay against every ratio, so the cap always wins
		for (int r = 0; r < 11; r++) begin
			@(posedge clk);
			adc_decimation_ratio <= 4'(r);
			nap;
			chk(decay_ms, cap[r]);
		end
		// mid-run reset drops the programmed sources back to legacy
		wr(`AGT_OFS_ATTACK, 8'h9c);
		@(posedge clk);
		sys_rst <= 1'b1;
		repeat (3) @(posedge clk);
		sys_rst <= 1'b0;
		nap;
		chk(attack_ms, 24'h7b);
		rd(`AGT_OFS_ATTACK, 8'h00);
		rd(`AGT_OFS_DECAY, 8'h00);
		// select bits cleared: legacy sources return
		wr(`AGT_OFS_ATTACK, 8'h7c);
		wr(`AGT_OFS_DECAY, 8'h7c);
		nap;
		chk(attack_ms, 24'h7b);
		chk(24'({attack_prog, decay_prog}), 24'h0);
		chk(decay_ms, 24'h1c8);
		for (int i = 0; i < 4; i++) begin
			wr(`AGT_OFS_PATH, pv[i]);
			nap;
			chk(24'({hpf_left_prog, hpf_right_prog, fx_on_adc, ~bus_det_en}),
				24'({pv[i][7], pv[i][6], pv[i][3], pv[i][2]}));
		end
		// detector off: an error leaves no trace
		pulse(1'b0);
		rd(`AGT_OFS_PATH, 8'h04);
		@(posedge clk);
		hpf_enable <= 1'b0;
		dacs_powered_down <= 1'b0;
		wr(`AGT_OFS_PATH, 8'hc8);
		nap;
		chk(24'({hpf_left_prog, hpf_right_prog, fx_on_adc, bus_det_en}), 24'h1);
		pulse(1'b1);
		rd(`AGT_OFS_PATH, 8'hc9);
		rd(`AGT_OFS_PATH, 8'hc8);
		// unmapped offset ignores writes and reads zero
		wr(8'h70, 8'hfc);
		rd(8'h70, 8'h00);
		report_and_stop;
	end
endmodule // tb
